// [src/sdc_pkg.sv]
// shared constants for the synthesizer divider configuration block
package sdc_pkg;
	// feedback ratio layout, unsigned 11.32 fixed point
	localparam int FB_INT_W  = 11;
	localparam int FB_FRAC_W = 32;
	localparam int FB_W      = FB_INT_W + FB_FRAC_W;
	// high-speed divider and post divider code widths
	localparam int HS_W      = 11;
	localparam int POST_W    = 3;
	// high-speed ratio limits: any value low, even only high
	localparam logic [HS_W-1:0] HS_MIN     = 11'h005;
	localparam logic [HS_W-1:0] HS_ODD_MAX = 11'h021;
	localparam logic [HS_W-1:0] HS_MAX     = 11'h7fe;
	// post divider codes at or above this all divide by 32
	localparam logic [POST_W-1:0] POST_CODE_SAT = 3'h5;
	// bit positions inside the shared packed byte
	localparam int PK_POST_MSB = 6;
	localparam int PK_POST_LSB = 4;
	localparam int PK_HS_MSB   = 2;
	localparam int PK_HS_LSB   = 0;
	// control voltage converter word and its mid-supply code
	localparam int              CV_W   = 12;
	localparam logic [CV_W-1:0] CV_MID = 12'h800;
	// full scale gain of 128 means unity, hence a shift of 7
	localparam int GAIN_W     = 8;
	localparam int GAIN_SHIFT = 7;
	// converter clock is the vco over rate divider over 8
	localparam int ADC_DECIM_SHIFT = 3;
	localparam int ADC_SEL_W       = 5;
	// tuning gain word width
	localparam int TUNE_W = 16;
	// reset values: 70 / 1 / 71.9036697 (156.75 MHz plan)
	localparam logic [HS_W-1:0]   RST_HS   = 11'h046;
	localparam logic [POST_W-1:0] RST_POST = 3'h0;
	localparam logic [FB_W-1:0]   RST_FB   = 43'h047e756e62a;
endpackage : sdc_pkg

// [src/sdc_div_if.sv]
// link between the vco model and the output divider chain
interface sdc_div_if;
	import sdc_pkg::*;
	logic              vco_tick;  // one vco half period elapsed
	logic [HS_W-1:0]   hs_ratio;  // accepted high-speed ratio
	logic [POST_W-1:0] post_code; // accepted post divider code
	logic              out_level; // divided output level

	modport core (output vco_tick, output hs_ratio, output post_code,
		input out_level);
	modport chain (input vco_tick, input hs_ratio, input post_code,
		output out_level);
endinterface : sdc_div_if

// [src/sdc_out_divider.sv]
// high-speed divider followed by the power-of-two post divider
module sdc_out_divider
	import sdc_pkg::*;
(
	input wire logic sys_clk,  // system clock
	input wire logic rst_n,    // synchronised reset, active low
	input wire logic clk_en,   // freezes all state while low
	sdc_div_if.chain dv        // ticks in, divided level out
);
	logic [HS_W-1:0] hs_cnt;       // half periods counted so far
	logic [HS_W-1:0] next_hs_cnt;
	logic            hs_lvl;       // high-speed divider output
	logic            next_hs_lvl;
	logic [4:0]      post_cnt;     // hs half periods counted
	logic [4:0]      next_post_cnt;
	logic            post_lvl;     // post divider output
	logic            next_post_lvl;
	logic [4:0]      post_last;    // last count before toggling
	logic            hs_edge;      // hs output toggles now

	// counting vco half periods gives a 50% duty cycle
	// for odd ratios too, without a separate correction stage
	always_comb begin
		next_hs_cnt = hs_cnt;
		next_hs_lvl = hs_lvl;
		hs_edge     = 1'b0;
		if (dv.vco_tick) begin
			if (hs_cnt >= dv.hs_ratio - 11'h001) begin
				next_hs_cnt = '0;
				next_hs_lvl = ~hs_lvl;
				hs_edge     = 1'b1;
			end else begin
				next_hs_cnt = hs_cnt + 11'h001;
			end
		end
	end

	// post divider: code 0..4 gives 2^code, above saturates at 32
	always_comb begin
		if (dv.post_code >= POST_CODE_SAT) begin
			post_last = 5'h1f;
		end else begin
			post_last = 5'((6'h01 << dv.post_code) - 6'h01);
		end
		next_post_cnt = post_cnt;
		next_post_lvl = post_lvl;
		if (hs_edge) begin
			if (post_cnt >= post_last) begin
				next_post_cnt = '0;
				next_post_lvl = ~post_lvl;
			end else begin
				next_post_cnt = post_cnt + 5'h01;
			end
		end
	end

	// register the chain; ratio 1 is simply the toggle every hs edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_cnt   <= '0;
			hs_lvl   <= 1'b0;
			post_cnt <= '0;
			post_lvl <= 1'b0;
		end else if (clk_en) begin
			hs_cnt   <= next_hs_cnt;
			hs_lvl   <= next_hs_lvl;
			post_cnt <= next_post_cnt;
			post_lvl <= next_post_lvl;
		end
	end

	assign dv.out_level = post_lvl;
endmodule : sdc_out_divider

// [src/sdc_synth_top.sv]
// divider configuration, vco model and converter timing top level
// How it works
// - post code 0-4 divides 2^code, else 32
// - high-speed ratio 5-33 any, 34-2046 even
// - odd high-speed ratios keep 50% duty cycle
// - output is vco over both divider ratios
// - vco tracks crystal times ratio, tuned by voltage
// - converter sample rate follows the vco frequency
// - all divider values are unsigned, positive
// - feedback ratio is 43-bit unsigned 11.32
// - high-speed divider is 11-bit unsigned integer
// - packed byte: post code 6:4, hs 2:0
module sdc_synth_top
	import sdc_pkg::*;
#(
	parameter int TUNE_SHIFT = 20  // tuning gain word scale, 2^-20
)
(
	input  wire logic                 sys_clk,
	input  wire logic                 arst_n,
	input  wire logic                 clk_en,
	input  wire logic                 cfg_load,
	input  wire logic [7:0]           cfg_hs_low_byte,
	input  wire logic [7:0]           cfg_packed_byte,
	input  wire logic [FB_W-1:0]      feedback_frac_ratio,
	input  wire logic [TUNE_W-1:0]    tuning_gain_ppm_per_volt,
	input  wire logic [GAIN_W-1:0]    ctrl_adc_full_scale_gain,
	input  wire logic [ADC_SEL_W-1:0] adc_rate_divider_sel,
	input  wire logic [CV_W-1:0]      control_voltage,
	output logic                      clk_out,
	output logic                      vco_tick,
	output logic                      adc_sample,
	output logic                      cfg_error,
	output logic [HS_W-1:0]           high_speed_out_divider,
	output logic [POST_W-1:0]         pow2_post_divider,
	output logic [FB_INT_W-1:0]       feedback_integer_part,
	output logic [FB_FRAC_W-1:0]      feedback_fraction_part
);
	// reset release through two flops
	logic rst_s1;
	logic rst_n;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// accepted configuration
	logic [HS_W-1:0]   hs_ratio;
	logic [HS_W-1:0]   next_hs_ratio;
	logic [POST_W-1:0] post_code;
	logic [POST_W-1:0] next_post_code;
	logic [FB_W-1:0]   fb_ratio;
	logic [FB_W-1:0]   next_fb_ratio;
	logic              next_cfg_error;
	logic [HS_W-1:0]   req_hs;        // ratio assembled from bytes
	logic              req_ok;        // requested ratio is legal

	// unpack the request and check it; a bad ratio leaves the old
	// setting running, since a stopped output is worse than a stale one
	always_comb begin
		req_hs = {cfg_packed_byte[PK_HS_MSB:PK_HS_LSB],
			cfg_hs_low_byte};
		req_ok = (req_hs >= HS_MIN) && (req_hs <= HS_MAX)
			&& !(req_hs[0] && (req_hs > HS_ODD_MAX));
		next_hs_ratio  = hs_ratio;
		next_post_code = post_code;
		next_fb_ratio  = fb_ratio;
		next_cfg_error = cfg_error;
		if (cfg_load) begin
			if (req_ok) begin
				next_hs_ratio  = req_hs;
				next_post_code = cfg_packed_byte[PK_POST_MSB:PK_POST_LSB];
				next_fb_ratio  = feedback_frac_ratio;
				next_cfg_error = 1'b0;
			end else begin
				next_cfg_error = 1'b1;
			end
		end
	end

	// configuration registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_ratio  <= RST_HS;
			post_code <= RST_POST;
			fb_ratio  <= RST_FB;
			cfg_error <= 1'b0;
		end else if (clk_en) begin
			hs_ratio  <= next_hs_ratio;
			post_code <= next_post_code;
			fb_ratio  <= next_fb_ratio;
			cfg_error <= next_cfg_error;
		end
	end

	// readback of the running setting, straight from flops
	always_comb begin
		high_speed_out_divider = hs_ratio;
		pow2_post_divider      = post_code;
		feedback_integer_part  = fb_ratio[FB_W-1:FB_FRAC_W];
		feedback_fraction_part = fb_ratio[FB_FRAC_W-1:0];
	end

	// control voltage pin: three flops, accepted once 2nd and 3rd agree
	logic [CV_W-1:0] cv_s1;
	logic [CV_W-1:0] cv_s2;
	logic [CV_W-1:0] cv_s3;
	logic [CV_W-1:0] cv_stable;
	logic [CV_W-1:0] next_cv_stable;
	logic [CV_W-1:0] cv_held;      // value taken at converter sample
	logic [CV_W-1:0] next_cv_held;

	// converter timing state
	logic [7:0]      adc_cnt;      // vco half periods since sample
	logic [7:0]      next_adc_cnt;
	logic            next_adc_sample;
	logic [7:0]      adc_last;

	// converter clock is vco / rate divider / 8
	always_comb begin
		next_cv_stable = (cv_s2 == cv_s3) ? cv_s3 : cv_stable;
		adc_last = 8'({adc_rate_divider_sel, 3'h0} - 8'h01);
		next_adc_cnt    = adc_cnt;
		next_adc_sample = 1'b0;
		next_cv_held    = cv_held;
		if (vco_tick) begin
			if (adc_cnt >= adc_last) begin
				next_adc_cnt    = '0;
				next_adc_sample = 1'b1;
				next_cv_held    = cv_stable;
			end else begin
				next_adc_cnt = adc_cnt + 8'h01;
			end
		end
	end

	// synchroniser and converter registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cv_s1      <= CV_MID;
			cv_s2      <= CV_MID;
			cv_s3      <= CV_MID;
			cv_stable  <= CV_MID;
			cv_held    <= CV_MID;
			adc_cnt    <= '0;
			adc_sample <= 1'b0;
		end else if (clk_en) begin
			cv_s1      <= control_voltage;
			cv_s2      <= cv_s1;
			cv_s3      <= cv_s2;
			cv_stable  <= next_cv_stable;
			cv_held    <= next_cv_held;
			adc_cnt    <= next_adc_cnt;
			adc_sample <= next_adc_sample;
		end
	end

	// vco model: phase accumulator whose step is the tuned ratio
	logic signed [21:0] cv_off;    // offset from mid supply, gained
	logic signed [82:0] tune_prod;
	logic signed [82:0] tune_sum;
	logic [FB_W-1:0]    nco_step;
	logic [FB_W-1:0]    nco_acc;
	logic [FB_W-1:0]    next_nco_acc;
	logic               next_vco_tick;

	// the step is ratio * (1 + gain * offset); carries mark vco
	// half periods, so the step must stay below 2^43 per cycle
	always_comb begin
		cv_off = 22'((($signed({1'b0, cv_held}) - $signed({1'b0, CV_MID}))
			* $signed({1'b0, ctrl_adc_full_scale_gain})) >>> GAIN_SHIFT);
		tune_prod = 83'($signed({1'b0, fb_ratio})
			* $signed({1'b0, tuning_gain_ppm_per_volt}) * cv_off);
		tune_sum = $signed({40'h0, fb_ratio})
			+ (tune_prod >>> TUNE_SHIFT);
		if (tune_sum[82]) begin
			nco_step = '0; // pulled below zero: hold still
		end else if (|tune_sum[81:FB_W]) begin
			nco_step = '1; // saturate rather than wrap
		end else begin
			nco_step = tune_sum[FB_W-1:0];
		end
		{next_vco_tick, next_nco_acc} = {1'b0, nco_acc}
			+ {1'b0, nco_step};
	end

	// accumulator registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nco_acc  <= '0;
			vco_tick <= 1'b0;
		end else if (clk_en) begin
			nco_acc  <= next_nco_acc;
			vco_tick <= next_vco_tick;
		end
	end

	// output divider chain
	sdc_div_if dv ();

	assign dv.vco_tick  = vco_tick;
	assign dv.hs_ratio  = hs_ratio;
	assign dv.post_code = post_code;

	sdc_out_divider u_out_divider (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.dv      (dv.chain)
	);

	// output flop after the chain
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_out <= 1'b0;
		end else if (clk_en) begin
			clk_out <= dv.out_level;
		end
	end
endmodule : sdc_synth_top

// [dv/sdc_host_model.sv]
// host model: packs and loads divider settings onto the device pins
module sdc_host_model
	import sdc_pkg::*;
(
	input wire logic			sys_clk,
	input wire logic			req,
	input wire logic [HS_W-1:0]		hs,
	input wire logic [POST_W-1:0]		post,
	input wire logic [FB_W-1:0]		fb,
	output logic				cfg_load,
	output logic [7:0]			hs_low,
	output logic [7:0]			packed_b,
	output logic [FB_W-1:0]			fb_out,
	output logic [ADC_SEL_W-1:0]		sel
);
	timeunit 1ns;
	timeprecision 1ns;
	// pins start on the factory plan so nothing floats at time zero
	initial {cfg_load, hs_low, packed_b, fb_out, sel} =
		{1'b0, 8'h46, 8'h00, RST_FB, 5'h10};
	// one-cycle load pulse; settings stay put until the next request
	always @(posedge sys_clk) begin
		cfg_load <= req;
		if (req) begin
			hs_low <= hs[7:0];
			packed_b <= {1'b0, post, 1'b0, hs[10:8]};
			fb_out <= fb;
			// rate divider from the truncated integer part only
			sel <= fb[42:32] < 11'h048 ? 5'h10 :
				fb[42:32] < 11'h04f ? 5'h12 :
				fb[42:32] < 11'h056 ? 5'h14 : 5'h16;
		end
	end
endmodule : sdc_host_model

// [dv/sdc_synth_checker.sv]
// port checks for the divider configuration top level
module sdc_synth_checker
	import sdc_pkg::*;
(
	input wire logic			sys_clk,
	input wire logic			arst_n,
	input wire logic			clk_en,
	input wire logic			cfg_load,
	input wire logic [7:0]			cfg_hs_low_byte,
	input wire logic [7:0]			cfg_packed_byte,
	input wire logic [FB_W-1:0]		feedback_frac_ratio,
	input wire logic			clk_out,
	input wire logic			vco_tick,
	input wire logic			adc_sample,
	input wire logic			cfg_error,
	input wire logic [HS_W-1:0]		high_speed_out_divider,
	input wire logic [POST_W-1:0]		pow2_post_divider,
	input wire logic [FB_INT_W-1:0]		feedback_integer_part,
	input wire logic [FB_FRAC_W-1:0]	feedback_fraction_part
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	logic [HS_W-1:0]	hs_in;		// ratio the pins present
	logic [POST_W-1:0]	post_in;	// post code the pins present
	logic			ok_in;		// presented ratio is legal
	assign hs_in = {cfg_packed_byte[2:0], cfg_hs_low_byte};
	assign post_in = cfg_packed_byte[6:4];
	assign ok_in = hs_in >= HS_MIN && hs_in <= HS_MAX
		&& (hs_in <= HS_ODD_MAX || !hs_in[0]);
	// a load counts only on an enabled edge
	sequence s_take;
		clk_en && cfg_load;
	endsequence
	AST_GOOD_HS: assert property (s_take ##0 ok_in |=> !cfg_error
		&& high_speed_out_divider == $past(hs_in)) else $error("ratio lost");
	AST_GOOD_POST: assert property (s_take ##0 ok_in |=>
		pow2_post_divider == $past(post_in)) else $error("post code lost");
	AST_GOOD_FB: assert property (s_take ##0 ok_in |=>
		{feedback_integer_part, feedback_fraction_part}
		== $past(feedback_frac_ratio)) else $error("ratio word lost");
	AST_BAD_KEEP: assert property (s_take ##0 !ok_in |=> cfg_error
		&& $stable(high_speed_out_divider) && $stable(pow2_post_divider))
		else $error("refused load changed the setting");
	AST_BAD_FB: assert property (s_take ##0 !ok_in |=>
		$stable(feedback_fraction_part) && $stable(feedback_integer_part))
		else $error("refused load changed the ratio word");
	AST_HOLD: assert property (!(clk_en && cfg_load) |=>
		$stable(high_speed_out_divider) && $stable(cfg_error))
		else $error("setting moved without a load");
	AST_HS_RANGE: assert property (high_speed_out_divider >= HS_MIN
		&& high_speed_out_divider <= HS_MAX && (!high_speed_out_divider[0]
		|| high_speed_out_divider <= HS_ODD_MAX)) else $error("bad ratio");
	AST_FREEZE: assert property (!clk_en |=> $stable(clk_out)
		&& $stable(vco_tick) && $stable(adc_sample)) else $error("not frozen");
endmodule : sdc_synth_checker
bind sdc_synth_top sdc_synth_checker u_chk (.*);

// [dv/tb_sdc_synth_top.sv]
// self-checking bench for the divider configuration top level
module tb_sdc_synth_top
	import sdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic			sys_clk = 1'b0;
	logic			arst_n = 1'b0;
	logic			clk_en = 1'b1;
	logic			req = 1'b0;	// host load request
	logic [HS_W-1:0]	hs = 11'h005;
	logic [POST_W-1:0]	post = 3'h0;
	logic [FB_W-1:0]	fb = 43'h0;
	logic			cfg_load, clk_out, vco_tick, adc_sample, cfg_error, v;
	logic			vt, va;		// tick and sample held while frozen
	logic [GAIN_W-1:0]	fsg = 8'h80;	// full scale gain the host loads
	int			pp, hh;		// planned post code and hs ratio
	logic [7:0]		hs_low, packed_b;
	logic [ADC_SEL_W-1:0]	sel;
	logic [HS_W-1:0]	hs_rb, eh, h;	// readback, expected, applied
	logic [POST_W-1:0]	post_rb, ep;
	logic [FB_INT_W-1:0]	fbi;
	logic [FB_FRAC_W-1:0]	fbf;
	logic [FB_W-1:0]	fb_in, ef, f;
	int			bad_count = 0;
	int			n_tests = 0;
	int			cyc = 0;
	int			seed = 32'h6e7dd566;
	int			t, a, g, g1, g2;
	// both ends of both ratio ranges, plus zero
	logic [HS_W-1:0]	corner [8] = '{11'h004, 11'h005, 11'h021,
		11'h022, 11'h023, 11'h7fe, 11'h7ff, 11'h000};
	always #50 sys_clk = ~sys_clk;
	sdc_host_model host (.sys_clk(sys_clk), .req(req), .hs(hs), .post(post),
		.fb(fb), .cfg_load(cfg_load), .hs_low(hs_low), .packed_b(packed_b),
		.fb_out(fb_in), .sel(sel));
	// voltage tied at mid supply so the vco rate is exact at any gain
	sdc_synth_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.cfg_load(cfg_load), .cfg_hs_low_byte(hs_low),
		.cfg_packed_byte(packed_b), .feedback_frac_ratio(fb_in),
		.tuning_gain_ppm_per_volt(16'h0100), .ctrl_adc_full_scale_gain(fsg),
		.adc_rate_divider_sel(sel), .control_voltage(CV_MID),
		.clk_out(clk_out), .vco_tick(vco_tick), .adc_sample(adc_sample),
		.cfg_error(cfg_error), .high_speed_out_divider(hs_rb),
		.pow2_post_divider(post_rb), .feedback_integer_part(fbi),
		.feedback_fraction_part(fbf));
	function automatic logic legal(input logic [HS_W-1:0] x);
		return x >= HS_MIN && x <= HS_MAX && (x <= HS_ODD_MAX || !x[0]);
	endfunction : legal
	// host plan: lowest vco first, smallest post ratio, next legal hs
	function automatic void plan(input real fout, output int p,
		output int n);
		real m;
		p = 0;
		m = 10.8e9 / fout;
		while (m > 2046.0 && p < 5) begin
			p++;
			m = m / 2.0;
		end
		n = $rtoi(m);
		if (real'(n) < m) n++;
		if (n > 33 && n[0]) n++;
	endfunction : plan
	// host gain: converter rate against its nominal 80 MHz
	function automatic int plan_gain(input logic [FB_W-1:0] w,
		input int s);
		real fvco;
		fvco = 152.6e6 * (real'(w) / 4294967296.0);
		return $rtoi(128.0 * 80.0e6 / (fvco / s / 8.0) + 0.5);
	endfunction : plan_gain
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// request at one edge, host pulses next, device takes the one after
	task automatic load(input logic [HS_W-1:0] x, input logic [POST_W-1:0] p,
		input logic [FB_W-1:0] w);
		@(posedge sys_clk);
		req <= 1'b1;
		hs <= x;
		post <= p;
		fb <= w;
		@(posedge sys_clk);
		req <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
	endtask : load
	task automatic count(input int n, output int nt, output int na);
		nt = 0;
		na = 0;
		repeat (n) begin
			@(negedge sys_clk);
			nt += vco_tick;
			na += adc_sample;
		end
	endtask : count
	// cycles until the output level next changes
	task automatic gap(output int n);
		logic s;
		s = clk_out;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (clk_out === s && n < 2000);
	endtask : gap
	task automatic rst_chk();
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({hs_rb, post_rb, fbi, fbf, cfg_error},
			{RST_HS, RST_POST, RST_FB, 1'b0});
		{eh, ep, ef} = {RST_HS, RST_POST, RST_FB};
		$display("reset test done");
	endtask : rst_chk
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	// a hang counts as a mismatch
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		rst_chk();
		for (int i = 0; i < 48; i++) begin
			h = i < 8 ? corner[i] : 11'($random(seed));
			f = 43'({$random(seed), $random(seed)});
			load(h, 3'(i), f);
			if (legal(h)) {eh, ep, ef} = {h, 3'(i), f};
			chk({hs_rb, post_rb, fbi, fbf}, {eh, ep, ef});
			chk(cfg_error, !legal(h));
		end
		$display("load test done");
		// factory plan for 156.75 MHz worked out the host's way
		plan(156.75e6, pp, hh);
		chk(hh, RST_HS);
		chk(pp, RST_POST);
		chk(real'(hh) * 156.75e6 <= 13.122222022e9, 1'b1);
		load(RST_HS, RST_POST, RST_FB);
		chk(sel, 5'h10);
		chk(plan_gain(RST_FB, sel), 119);
		fsg <= 8'(plan_gain(RST_FB, sel));
		$display("plan test done");
		// vco rate is fb over 2^43; converter every sel*8 ticks
		for (int k = 1; k <= 2; k++) begin
			load(11'h005, 3'h0, 43'h40000000000 >> (k - 1));
			repeat (400) @(negedge sys_clk);
			count(1408, t, a);
			chk(t, 1408 >> k);
			chk(a, 8 >> k);
		end
		$display("rate test done");
		for (int c = 0; c < 8; c++) begin
			load(11'h005, 3'(c), 43'h40000000000);
			repeat (2) gap(g);
			gap(g1);
			gap(g2);
			chk(g1, 10 << (c > 5 ? 5 : c));
			chk(g2, 10 << (c > 5 ? 5 : c));
		end
		$display("divider test done");
		@(posedge sys_clk);
		clk_en <= 1'b0;
		@(negedge sys_clk);
		v = clk_out;
		vt = vco_tick;
		va = adc_sample;
		load(11'h004, 3'h1, 43'h0);
		count(100, t, a);
		chk(t, vt ? 100 : 0);
		chk(a, va ? 100 : 0);
		chk({clk_out, cfg_error, hs_rb}, {v, 1'b0, 11'h005});
		@(posedge sys_clk);
		clk_en <= 1'b1;
		$display("freeze test done");
		@(posedge sys_clk);
		arst_n <= 1'b0;
		rst_chk();
		summarize();
	end
endmodule : tb_sdc_synth_top
